// ===== bsc_pkg.sv
// Purpose: Shared types and constants for the burst SRAM cycle control block.
// Assumes: One clock domain; bus pins are synchronous to sys_clk.
package bsc_pkg;

  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam int LANES = 4;
  localparam int LANE_W = 8;

  // Synchronous control pins, sampled together on each edge
  typedef struct packed {
    logic primary_chip_enable_n;
    logic depth_enable_high;
    logic depth_enable_low_n;
    logic processor_address_strobe_n;
    logic controller_address_strobe_n;
    logic burst_advance_n;
    logic all_lanes_write_n;
    logic write_qualifier_n;
    logic [LANES-1:0] byte_lane_write_n;
  } bsc_ctrl_t;

  // Idle bus: unselected, no strobes, no writes
  localparam bsc_ctrl_t CTRL_RST = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 4'hf};

  // Unclocked pins as {output_enable_n, sleep_request, burst_order_select_n}
  localparam logic [2:0] ASYNC_RST = 3'h5;
  localparam int ASYNC_OE = 2;
  localparam int ASYNC_SLEEP = 1;
  localparam int ASYNC_ORDER = 0;

  localparam logic [1:0] CNT_RST = 2'h0;
  localparam logic [1:0] CNT_STEP = 2'h1;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ACTIVE = 3'b010,
    ST_SLEEP = 3'b100
  } bsc_state_t;
  localparam int ST_SLEEP_BIT = 2;

  // Lane write enables decoded from the three write controls
  function automatic logic [LANES-1:0] lane_write(input logic all_n, input logic qual_n,
                                                  input logic [LANES-1:0] lane_n);
    logic [LANES-1:0] en;
    en = 4'h0;
    if (!all_n) begin
      en = 4'hf;
    end else if (!qual_n) begin
      en = ~lane_n;
    end
    return en;
  endfunction : lane_write

endpackage : bsc_pkg

// ===== bsc_cycle_ctrl.sv
// Purpose: Cycle control of a pipelined burst SRAM: select, begin, continue, suspend, sleep.
// Assumes: Bus pins synchronous to sys_clk; array read data valid in the same cycle as arr_read.
// Notes: Output enable, sleep and order select are synchronised, so they act two edges late.
`timescale 1ns/1ns
module bsc_cycle_ctrl (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Synchronous bus pins
  input wire bsc_pkg::bsc_ctrl_t ctrl_pins,
  input wire logic [bsc_pkg::ADDR_W-1:0] addr_pins,
  input wire logic [bsc_pkg::DATA_W-1:0] data_lanes_in,
  output logic [bsc_pkg::DATA_W-1:0] data_lanes_out,
  output logic data_lanes_oe,
  // Unclocked pins
  input wire logic output_enable_n,
  input wire logic sleep_request,
  input wire logic burst_order_select_n,
  // Array side
  output logic [bsc_pkg::ADDR_W-1:0] arr_addr,
  output logic [bsc_pkg::DATA_W-1:0] arr_wdata,
  output logic [bsc_pkg::LANES-1:0] arr_lane_we,
  output logic arr_read,
  input wire logic [bsc_pkg::DATA_W-1:0] arr_rdata,
  // Status
  output logic low_power
);

  bsc_pkg::bsc_ctrl_t ctrl_reg;
  logic [bsc_pkg::ADDR_W-1:0] addr_reg;
  logic [bsc_pkg::DATA_W-1:0] din_reg;
  logic [2:0] async_s1_reg;
  logic [2:0] async_s2_reg;
  bsc_pkg::bsc_state_t state_reg;
  bsc_pkg::bsc_state_t state_next;
  logic [bsc_pkg::ADDR_W-1:0] base_reg;
  logic [1:0] cnt_reg;
  logic [1:0] cnt_next;
  logic [bsc_pkg::ADDR_W-1:0] arr_addr_reg;
  logic [bsc_pkg::ADDR_W-1:0] addr_next;
  logic [bsc_pkg::DATA_W-1:0] arr_wdata_reg;
  logic [bsc_pkg::LANES-1:0] arr_we_reg;
  logic arr_read_reg;
  logic [bsc_pkg::DATA_W-1:0] dout_reg;
  logic oe_reg;

  // Input registers; the pins are on our clock so no synchroniser is needed
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_reg <= bsc_pkg::CTRL_RST;
      addr_reg <= '0;
      din_reg <= '0;
    end else begin
      ctrl_reg <= ctrl_pins;
      addr_reg <= addr_pins;
      din_reg <= data_lanes_in;
    end
  end

  // Two-flop synchroniser for the unclocked pins; only stage two is read
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      async_s1_reg <= bsc_pkg::ASYNC_RST;
      async_s2_reg <= bsc_pkg::ASYNC_RST;
    end else begin
      async_s1_reg <= {output_enable_n, sleep_request, burst_order_select_n};
      async_s2_reg <= async_s1_reg;
    end
  end

  wire oe_n_s = async_s2_reg[bsc_pkg::ASYNC_OE];
  wire sleep_s = async_s2_reg[bsc_pkg::ASYNC_SLEEP];
  wire linear_s = ~async_s2_reg[bsc_pkg::ASYNC_ORDER];
  wire awake = ~sleep_s;

  wire selected = ~ctrl_reg.primary_chip_enable_n & ctrl_reg.depth_enable_high &
                  ~ctrl_reg.depth_enable_low_n;
  // processor strobe blocked by primary enable
  wire processor_address_strobe_n_act = ~ctrl_reg.processor_address_strobe_n & ~ctrl_reg.primary_chip_enable_n;
  wire controller_address_strobe_n_act = ~ctrl_reg.controller_address_strobe_n;
  wire strobe = processor_address_strobe_n_act | controller_address_strobe_n_act;

  wire [bsc_pkg::LANES-1:0] lane_wr = bsc_pkg::lane_write(ctrl_reg.all_lanes_write_n,
      ctrl_reg.write_qualifier_n, ctrl_reg.byte_lane_write_n);
  wire is_write = |lane_wr;

  wire go_desel = awake & strobe & ~selected;
  wire go_rd = awake & selected & (processor_address_strobe_n_act | (controller_address_strobe_n_act & ~is_write));
  wire go_wr = awake & selected & ~processor_address_strobe_n_act & controller_address_strobe_n_act & is_write;
  wire go_begin = go_rd | go_wr;
  wire burst_on = (state_reg == bsc_pkg::ST_ACTIVE);
  wire go_cont = awake & burst_on & ~strobe & ~ctrl_reg.burst_advance_n;
  wire go_susp = awake & burst_on & ~strobe & ctrl_reg.burst_advance_n;
  wire go_acc = go_begin | go_cont | go_susp;
  wire acc_write = go_begin ? go_wr : is_write;

  // burst counter; suspend holds the count
  assign cnt_next = go_begin ? bsc_pkg::CNT_RST :
                    go_cont ? 2'(cnt_reg + bsc_pkg::CNT_STEP) : cnt_reg;
  wire [1:0] lo_lin = 2'(base_reg[1:0] + cnt_next);
  wire [1:0] lo_ilv = base_reg[1:0] ^ cnt_next;
  assign addr_next = go_begin ? addr_reg :
                     {base_reg[bsc_pkg::ADDR_W-1:2], linear_s ? lo_lin : lo_ilv};

  // a deselect must not wake the device; only a read or write begin does
  wire desel_idle = go_desel & ~state_reg[bsc_pkg::ST_SLEEP_BIT];

  // state: sleep wins, low power holds until a command
  assign state_next = sleep_s ? bsc_pkg::ST_SLEEP :
                      go_begin ? bsc_pkg::ST_ACTIVE :
                      desel_idle ? bsc_pkg::ST_IDLE : state_reg;

  // Burst state and base address
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= bsc_pkg::ST_IDLE;
      base_reg <= '0;
      cnt_reg <= bsc_pkg::CNT_RST;
    end else begin
      state_reg <= state_next;
      base_reg <= go_begin ? addr_reg : base_reg;
      cnt_reg <= cnt_next;
    end
  end

  // Array access issue; stored contents are untouched while idle or asleep
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      arr_addr_reg <= '0;
      arr_we_reg <= '0;
      arr_read_reg <= 1'b0;
      arr_wdata_reg <= '0;
    end else begin
      arr_addr_reg <= go_acc ? addr_next : arr_addr_reg;
      arr_we_reg <= (go_acc & acc_write) ? lane_wr : '0;
      arr_read_reg <= go_acc & ~acc_write;
      arr_wdata_reg <= din_reg;
    end
  end

  // output register loads one edge after the array read
  // drive only for reads with enable low and awake
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      dout_reg <= '0;
      oe_reg <= 1'b0;
    end else begin
      dout_reg <= arr_read_reg ? arr_rdata : dout_reg;
      oe_reg <= arr_read_reg & ~oe_n_s & ~sleep_s;
    end
  end

  assign data_lanes_out = dout_reg;
  assign data_lanes_oe = oe_reg;
  assign arr_addr = arr_addr_reg;
  assign arr_wdata = arr_wdata_reg;
  assign arr_lane_we = arr_we_reg;
  assign arr_read = arr_read_reg;
  assign low_power = state_reg[bsc_pkg::ST_SLEEP_BIT];

  // Checks on the decode and pipeline
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  a_global_write_all: assert property (
    (go_acc & acc_write & ~ctrl_reg.all_lanes_write_n) |=> arr_lane_we == 4'hf)
    else $error("all-lanes write did not write every lane");
  a_lane_write_only: assert property (
    (go_acc & acc_write & ctrl_reg.all_lanes_write_n) |=>
      arr_lane_we == ~$past(ctrl_pins.byte_lane_write_n, 2))
    else $error("lane write enables do not match lane inputs");
  a_deselect_float: assert property (
    go_desel |=> (!arr_read && arr_lane_we == 4'h0) ##1 !data_lanes_oe)
    else $error("deselect did not float data");
  a_begin_ext_addr: assert property (
    go_begin |=> arr_addr == $past(addr_pins, 2))
    else $error("begin did not use external address");
  a_processor_address_strobe_n_read: assert property (
    (go_begin & processor_address_strobe_n_act) |=> arr_read && arr_lane_we == 4'h0)
    else $error("processor strobe did not begin a read");
  a_suspend_hold: assert property (
    go_susp |=> arr_addr == $past(arr_addr) && (arr_read || arr_lane_we != 4'h0))
    else $error("suspend did not repeat current address");
  a_linear_step: assert property (
    (go_cont & linear_s) |=> arr_addr[1:0] == 2'($past(arr_addr[1:0]) + 2'h1))
    else $error("linear burst did not step by one");
  a_write_float: assert property (
    (arr_lane_we != 4'h0) |=> !data_lanes_oe)
    else $error("data driven during a write");
  a_read_pipe: assert property (
    (arr_read & ~oe_n_s & ~sleep_s) |=> data_lanes_oe && data_lanes_out == $past(arr_rdata))
    else $error("read data not registered one edge later");
  a_sleep_quiet: assert property (
    sleep_s |=> !data_lanes_oe && !arr_read && arr_lane_we == 4'h0 && low_power)
    else $error("sleep did not quiet the device");
  a_deselect_clears: assert property (
    (go_desel & awake) |=> !burst_on)
    else $error("deselect left a burst active");
  a_sleep_holds: assert property (
    (low_power & ~go_begin) |=> low_power)
    else $error("low power left without a command");
  a_begin_write: assert property (
    go_wr |=> !arr_read && arr_lane_we != 4'h0)
    else $error("controller strobe write did not write");
  a_continue_read: assert property (
    (go_cont & ~is_write) |=> arr_read && arr_lane_we == 4'h0)
    else $error("continued read did not read");

  c_begin_read: cover property (go_rd ##1 go_cont ##1 go_cont ##1 go_cont);
  c_begin_write: cover property (go_wr ##1 go_susp ##1 go_cont);
  c_sleep_wake: cover property (low_power ##1 !sleep_s ##[1:8] go_begin);
  c_deselect: cover property (go_begin ##[1:4] go_desel);
  c_write_burst: cover property (go_wr ##1 go_cont);

endmodule : bsc_cycle_ctrl

// ===== bsc_array_model.sv
// Purpose: Behavioural array behind the cycle control, 256 words deep.
// Assumes: Read data is needed only while arr_read is high.
// Notes: Outside reads the data lines show the inverted word, so stale samples fail.
`timescale 1ns/1ns
module bsc_array_model (
  // Clock
  input wire logic sys_clk,
  // Array side
  input wire logic [bsc_pkg::ADDR_W-1:0] arr_addr,
  input wire logic [bsc_pkg::DATA_W-1:0] arr_wdata,
  input wire logic [bsc_pkg::LANES-1:0] arr_lane_we,
  input wire logic arr_read,
  output logic [bsc_pkg::DATA_W-1:0] arr_rdata
);
  logic [bsc_pkg::DATA_W-1:0] mem [256];
  logic [bsc_pkg::DATA_W-1:0] word;
  // Scrambled outside the strobe, since a real array holds nothing there
  assign word = mem[arr_addr[7:0]];
  assign arr_rdata = arr_read ? word : ~word;
  // one lane each: a lane enable writes only its byte
  always_ff @(posedge sys_clk) begin
    for (int i = 0; i < bsc_pkg::LANES; i++) begin
      if (arr_lane_we[i]) begin
        mem[arr_addr[7:0]][i*8 +: 8] <= arr_wdata[i*8 +: 8];
      end
    end
  end
endmodule : bsc_array_model

// ===== burst_sram_cycle_control_tb.sv
// Purpose: Self-checking bench for the burst SRAM cycle control.
// Assumes: Inputs change on the falling edge; array model behind the block.
// Notes: Unclocked pins act two edges late, so scenarios idle before they look.
`timescale 1ns/1ns
module burst_sram_cycle_control_tb;
  logic sys_clk, reset_n, output_enable_n, sleep_request, burst_order_select_n;
  logic arr_read, data_lanes_oe, low_power;
  bsc_pkg::bsc_ctrl_t ctrl_pins, rd, wr, cont, desel, c;
  logic [bsc_pkg::ADDR_W-1:0] addr_pins, arr_addr;
  logic [bsc_pkg::DATA_W-1:0] data_lanes_in, data_lanes_out, arr_wdata, arr_rdata;
  logic [bsc_pkg::LANES-1:0] arr_lane_we;
  int errors, n_checks;

  bsc_cycle_ctrl u_dut (.sys_clk(sys_clk), .reset_n(reset_n), .ctrl_pins(ctrl_pins),
    .addr_pins(addr_pins), .data_lanes_in(data_lanes_in), .data_lanes_out(data_lanes_out),
    .data_lanes_oe(data_lanes_oe), .output_enable_n(output_enable_n),
    .sleep_request(sleep_request), .burst_order_select_n(burst_order_select_n),
    .arr_addr(arr_addr), .arr_wdata(arr_wdata), .arr_lane_we(arr_lane_we),
    .arr_read(arr_read), .arr_rdata(arr_rdata), .low_power(low_power));
  bsc_array_model u_arr (.sys_clk(sys_clk), .arr_addr(arr_addr), .arr_wdata(arr_wdata),
    .arr_lane_we(arr_lane_we), .arr_read(arr_read), .arr_rdata(arr_rdata));

  // Free-running clock
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // Called at a falling edge; returns one cycle later
  task automatic drive(input bsc_pkg::bsc_ctrl_t p, input logic [15:0] a, input logic [31:0] d);
    ctrl_pins = p;
    addr_pins = a;
    data_lanes_in = d;
    @(negedge sys_clk);
  endtask : drive

  task automatic t_read(input logic [15:0] a, input logic [31:0] exp, input logic oe_n);
    output_enable_n = oe_n;
    drive(desel, 16'h0, 32'h0);
    drive(rd, a, 32'h0);
    drive(desel, 16'h0, 32'h0);
    chk(arr_read, 1'b1);
    drive(desel, 16'h0, 32'h0);
    chk(data_lanes_out, exp);
    chk(data_lanes_oe, !oe_n);
    output_enable_n = 1'b0;
  endtask : t_read

  task automatic t_writes;
    drive(wr, 16'h0010, 32'h11223344);
    drive(desel, 16'h0, 32'h0);
    chk(arr_lane_we, 4'hf);
    chk(arr_wdata, 32'h11223344);
    c = wr;
    c.all_lanes_write_n = 1'b1;
    c.write_qualifier_n = 1'b0;
    c.byte_lane_write_n = 4'hd;
    drive(c, 16'h0010, 32'haabbccdd);
    drive(desel, 16'h0, 32'h0);
    chk(arr_lane_we, 4'h2);
    drive(desel, 16'h0, 32'h0);
    chk(data_lanes_oe, 1'b0);
    t_read(16'h0010, 32'h1122cc44, 1'b0);
    t_read(16'h0010, 32'h1122cc44, 1'b1);
  endtask : t_writes

  task automatic t_burst(input logic order, input logic [15:0] s);
    logic [1:0] lo;
    burst_order_select_n = order;
    drive(desel, 16'h0, 32'h0);
    drive(rd, s, 32'h0);
    for (int i = 0; i < 4; i++) begin
      drive(cont, 16'h0, 32'h0);
      lo = order ? (s[1:0] ^ 2'(i)) : (s[1:0] + 2'(i));
      chk(arr_addr, {s[15:2], lo});
    end
    for (int i = 0; i < 2; i++) begin
      drive(bsc_pkg::CTRL_RST, 16'h0, 32'h0);
      chk(arr_addr, s);
    end
    drive(desel, 16'h0, 32'h0);
    drive(cont, 16'h0, 32'h0);
    drive(cont, 16'h0, 32'h0);
    chk(arr_read, 1'b0);
  endtask : t_burst

  // Strobes while not selected must start nothing
  task automatic t_unsel(input int k);
    c = rd;
    if (k == 0) c.depth_enable_high = 1'b0;
    if (k == 1) c.depth_enable_low_n = 1'b1;
    if (k == 2) c.primary_chip_enable_n = 1'b1;
    drive(c, 16'h0030, 32'h0);
    drive(desel, 16'h0, 32'h0);
    chk(arr_read, 1'b0);
  endtask : t_unsel

  task automatic t_sleep;
    sleep_request = 1'b1;
    repeat (3) drive(desel, 16'h0, 32'h0);
    chk(low_power, 1'b1);
    sleep_request = 1'b0;
    repeat (3) drive(desel, 16'h0, 32'h0);
    chk(low_power, 1'b1);
    t_read(16'h0010, 32'h1122cc44, 1'b0);
    chk(low_power, 1'b0);
  endtask : t_sleep

  task automatic final_report;
    $display("checks=%0d errors=%0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : final_report

  // Run takes about 53 cycles; allow ample margin
  initial begin
    #200000;
    errors++;
    final_report();
  end

  initial begin
    desel = bsc_pkg::CTRL_RST;
    desel.controller_address_strobe_n = 1'b0;
    wr = desel;
    wr.primary_chip_enable_n = 1'b0;
    wr.depth_enable_high = 1'b1;
    wr.depth_enable_low_n = 1'b0;
    wr.all_lanes_write_n = 1'b0;
    rd = wr;
    rd.processor_address_strobe_n = 1'b0;
    rd.controller_address_strobe_n = 1'b1;
    cont = bsc_pkg::CTRL_RST;
    cont.burst_advance_n = 1'b0;
    {reset_n, output_enable_n, sleep_request, burst_order_select_n} = 4'h1;
    {ctrl_pins, addr_pins, data_lanes_in} = {desel, 16'h0, 32'h0};
    // Count rising edges: the clock's first step from unknown may look like a fall
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    reset_n = 1'b1;
    t_writes();
    t_burst(1'b0, 16'h0023);
    t_burst(1'b1, 16'h0021);
    for (int k = 0; k < 3; k++) t_unsel(k);
    t_sleep();
    final_report();
  end
endmodule : burst_sram_cycle_control_tb
